// ### inc/sync_serial_pkg.sv
// Constants and types for the synchronous serial master port
package sync_serial_pkg;
    // ==================================================
    // Register indices and byte addresses
    localparam logic [7:0] IDX_STATUS    = 8'h10;
    localparam logic [7:0] IDX_CONTROL   = 8'h12;
    localparam logic [7:0] IDX_TX1       = 8'h14;
    localparam logic [7:0] IDX_TX0       = 8'h16;
    localparam logic [7:0] IDX_RX        = 8'h18;
    localparam logic [7:0] IDX_IRQ_STS   = 8'h1a;
    localparam logic [7:0] IDX_IRQ_EN    = 8'h1c;
    localparam logic [7:0] IDX_IRQ_CLR   = 8'h1e;
    localparam logic [7:0] ADDR_STATUS   = 8'(IDX_STATUS * 4);
    localparam logic [7:0] ADDR_CONTROL  = 8'(IDX_CONTROL * 4);
    localparam logic [7:0] ADDR_TX1      = 8'(IDX_TX1 * 4);
    localparam logic [7:0] ADDR_TX0      = 8'(IDX_TX0 * 4);
    localparam logic [7:0] ADDR_RX       = 8'(IDX_RX * 4);
    localparam logic [7:0] ADDR_IRQ_STS  = 8'(IDX_IRQ_STS * 4);
    localparam logic [7:0] ADDR_IRQ_EN   = 8'(IDX_IRQ_EN * 4);
    localparam logic [7:0] ADDR_IRQ_CLR  = 8'(IDX_IRQ_CLR * 4);
    // ==================================================
    // Field positions and reset values
    localparam int         STS_BUSY      = 0;
    localparam int         STS_DONE      = 1;
    localparam int         STS_ERR       = 2;
    localparam int         CTL_SEL0      = 0;
    localparam int         CTL_SEL1      = 1;
    localparam int         CTL_DIV_LO    = 2;
    localparam int         IRQ_DONE      = 0;
    localparam int         IRQ_ERR       = 1;
    localparam logic [3:0] CONTROL_RESET = 4'h0;
    localparam logic [2:0] LAST_BIT      = 3'h7;
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;
    // ==================================================
    // Shift engine states, Gray along idle-low-high
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_LOW  = 2'h1,
        ST_HIGH = 2'h3
    } serial_state_type;
endpackage : sync_serial_pkg

// ### rtl/sync_serial_master_port.sv
// Synchronous serial master port with AXI4-Lite register slave
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ns
module sync_serial_master_port (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic [2:0]  awprot,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic [2:0]  arprot,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    output logic             serial_clock,
    input  wire logic        serial_data_in,
    output logic             serial_data_out,
    output logic             serial_data_oe_n,
    output logic             select_enable_out0,
    output logic             select_enable_out1,
    output logic             irq
);
    // ==================================================
    // State
    typedef struct packed {
        logic                             awready;
        logic                             wready;
        logic                             aw_held;
        logic [7:0]                       aw_addr;
        logic                             w_held;
        logic [31:0]                      w_data;
        logic [3:0]                       w_strb;
        logic                             bvalid;
        logic [1:0]                       bresp;
        logic                             arready;
        logic                             rvalid;
        logic [1:0]                       rresp;
        logic [31:0]                      rdata;
        logic [3:0]                       ctrl;
        logic                             busy;
        logic                             done;
        logic                             err;
        logic                             rx_mode;
        sync_serial_pkg::serial_state_type state;
        logic [3:0]                       cnt;
        logic [2:0]                       bit_cnt;
        logic [7:0]                       shift;
        logic [7:0]                       rx_byte;
        logic                             sclk;
        logic                             data_out;
        logic                             oe_n;
        logic [2:0]                       sync;
        logic                             filt;
        logic [1:0]                       irq_status;
        logic [1:0]                       irq_en;
        logic                             irq;
    } port_state_type;

    port_state_type q;
    port_state_type next_q;
    logic           wr_go;
    logic           rd_go;
    logic           done_set;
    logic           err_set;
    logic           done_clr;
    logic           sel_idle;
    logic [1:0]     irq_clr;
    logic [3:0]     half_m1;
    logic [7:0]     tx_byte;
    logic           tx_start;
    logic           rx_start;
    logic           filt_now;

    localparam port_state_type RESET_STATE = '{
        awready: 1'b1, wready: 1'b1, arready: 1'b1,
        ctrl: sync_serial_pkg::CONTROL_RESET,
        state: sync_serial_pkg::ST_IDLE,
        oe_n: 1'b1, default: '0};

    // ==================================================
    // Next state
    always_comb begin
        next_q   = q;
        done_set = 1'b0;
        err_set  = 1'b0;
        done_clr = 1'b0;
        irq_clr  = 2'h0;
        tx_start = 1'b0;
        rx_start = 1'b0;
        tx_byte  = q.w_data[7:0];
        sel_idle = !q.ctrl[sync_serial_pkg::CTL_SEL0]
                   && !q.ctrl[sync_serial_pkg::CTL_SEL1];
        // Divide by 2,4,8,16: half period is 1,2,4,8 clocks
        half_m1  = 4'((4'h1 << q.ctrl[sync_serial_pkg::CTL_DIV_LO +: 2])
                      - 4'h1);
        filt_now = (q.sync[1] == q.sync[2]) ? q.sync[2] : q.filt;
        wr_go    = q.aw_held && q.w_held && !q.bvalid;
        rd_go    = arvalid && q.arready;

        // Three-stage input filter; first stage feeds only the second
        // Agreed level used at once, saving a clock for the /8 receive
        next_q.sync = {q.sync[1:0], serial_data_in};
        next_q.filt = filt_now;

        // Write address and data are taken in either order
        if (awvalid && q.awready) begin
            next_q.aw_held = 1'b1;
            next_q.aw_addr = awaddr;
            next_q.awready = 1'b0;
        end
        if (wvalid && q.wready) begin
            next_q.w_held = 1'b1;
            next_q.w_data = wdata;
            next_q.w_strb = wstrb;
            next_q.wready = 1'b0;
        end
        if (q.bvalid && bready) begin
            next_q.bvalid  = 1'b0;
            next_q.awready = 1'b1;
            next_q.wready  = 1'b1;
        end
        if (wr_go) begin
            next_q.aw_held = 1'b0;
            next_q.w_held  = 1'b0;
            next_q.bvalid  = 1'b1;
            next_q.bresp   = sync_serial_pkg::RESP_OKAY;
            if (q.aw_addr == sync_serial_pkg::ADDR_CONTROL) begin
                if (q.w_strb[0]) begin
                    next_q.ctrl = q.w_data[3:0];
                end
            end else if (q.aw_addr == sync_serial_pkg::ADDR_TX0
                         || q.aw_addr == sync_serial_pkg::ADDR_TX1) begin
                done_clr = 1'b1;
                if (q.busy) begin
                    err_set = 1'b1;
                end else if (q.w_strb[0]) begin
                    tx_start = 1'b1;
                end
            end else if (q.aw_addr == sync_serial_pkg::ADDR_IRQ_EN) begin
                next_q.irq_en = q.w_data[1:0];
            end else if (q.aw_addr == sync_serial_pkg::ADDR_IRQ_CLR) begin
                irq_clr = q.w_data[1:0];
            end else if (q.aw_addr != sync_serial_pkg::ADDR_STATUS
                         && q.aw_addr != sync_serial_pkg::ADDR_RX
                         && q.aw_addr != sync_serial_pkg::ADDR_IRQ_STS) begin
                next_q.bresp = sync_serial_pkg::RESP_SLVERR;
            end
        end

        // Read channel; reading receive data also starts a receive
        if (q.rvalid && rready) begin
            next_q.rvalid  = 1'b0;
            next_q.arready = 1'b1;
        end
        if (rd_go) begin
            next_q.arready = 1'b0;
            next_q.rvalid  = 1'b1;
            next_q.rresp   = sync_serial_pkg::RESP_OKAY;
            next_q.rdata   = 32'h0;
            if (araddr == sync_serial_pkg::ADDR_STATUS) begin
                next_q.rdata[2:0] = {q.err && !sel_idle,
                                     q.done, q.busy};
                done_clr = 1'b1;
            end else if (araddr == sync_serial_pkg::ADDR_CONTROL) begin
                next_q.rdata[3:0] = q.ctrl;
            end else if (araddr == sync_serial_pkg::ADDR_RX) begin
                next_q.rdata[7:0] = q.rx_byte;
                done_clr = 1'b1;
                if (q.busy) begin
                    err_set = 1'b1;
                end else if (!tx_start) begin
                    rx_start = 1'b1;
                end
            end else if (araddr == sync_serial_pkg::ADDR_IRQ_STS) begin
                next_q.rdata[1:0] = q.irq_status;
            end else if (araddr == sync_serial_pkg::ADDR_IRQ_EN) begin
                next_q.rdata[1:0] = q.irq_en;
            end else if (araddr == sync_serial_pkg::ADDR_TX0
                         || araddr == sync_serial_pkg::ADDR_TX1
                         || araddr == sync_serial_pkg::ADDR_IRQ_CLR) begin
                next_q.rdata = 32'h0;
            end else begin
                next_q.rresp = sync_serial_pkg::RESP_SLVERR;
            end
        end

        // ==================================================
        // Shift engine
        case (q.state)
            sync_serial_pkg::ST_LOW: begin
                if (q.cnt == 4'h0) begin
                    next_q.sclk  = 1'b1;
                    next_q.state = sync_serial_pkg::ST_HIGH;
                    next_q.cnt   = half_m1;
                    if (q.rx_mode) begin
                        // Filter delay limits receive to slower dividers
                        next_q.shift = {q.shift[6:0], filt_now};
                    end
                    if (q.bit_cnt == sync_serial_pkg::LAST_BIT) begin
                        done_set = 1'b1;
                        if (q.rx_mode) begin
                            next_q.rx_byte = {q.shift[6:0], filt_now};
                        end
                    end
                end else begin
                    next_q.cnt = q.cnt - 4'h1;
                end
            end
            sync_serial_pkg::ST_HIGH: begin
                if (q.cnt == 4'h0) begin
                    next_q.sclk = 1'b0;
                    if (q.bit_cnt == sync_serial_pkg::LAST_BIT) begin
                        next_q.state = sync_serial_pkg::ST_IDLE;
                        next_q.busy  = 1'b0;
                        next_q.oe_n  = 1'b1;
                    end else begin
                        next_q.state   = sync_serial_pkg::ST_LOW;
                        next_q.cnt     = half_m1;
                        next_q.bit_cnt = q.bit_cnt + 3'h1;
                        if (!q.rx_mode) begin
                            next_q.shift    = {q.shift[6:0], 1'b0};
                            next_q.data_out = q.shift[6];
                        end
                    end
                end else begin
                    next_q.cnt = q.cnt - 4'h1;
                end
            end
            default: begin
                next_q.sclk = 1'b0;
            end
        endcase

        if (tx_start || rx_start) begin
            next_q.state    = sync_serial_pkg::ST_LOW;
            next_q.busy     = 1'b1;
            next_q.cnt      = half_m1;
            next_q.bit_cnt  = 3'h0;
            next_q.rx_mode  = rx_start;
            next_q.shift    = tx_start ? tx_byte : 8'h0;
            next_q.data_out = tx_start && tx_byte[7];
            // Line released on receive so only the peripheral drives
            next_q.oe_n     = rx_start;
        end

        // ==================================================
        // Flags; a set in the same cycle as a clear wins
        next_q.done = (q.done && !(done_clr || sel_idle))
                      || done_set;
        next_q.err  = (q.err && !sel_idle) || err_set;
        next_q.irq_status = (q.irq_status & ~irq_clr)
                            | {err_set, done_set};
        next_q.irq = |(next_q.irq_status & q.irq_en);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= RESET_STATE;
        end else begin
            q <= next_q;
        end
    end

    // ==================================================
    // Outputs
    assign awready            = q.awready;
    assign wready             = q.wready;
    assign bresp              = q.bresp;
    assign bvalid             = q.bvalid;
    assign arready            = q.arready;
    assign rdata              = q.rdata;
    assign rresp              = q.rresp;
    assign rvalid             = q.rvalid;
    assign serial_clock       = q.sclk;
    assign serial_data_out    = q.data_out;
    assign serial_data_oe_n   = q.oe_n;
    assign select_enable_out0 = q.ctrl[sync_serial_pkg::CTL_SEL0];
    assign select_enable_out1 = q.ctrl[sync_serial_pkg::CTL_SEL1];
    assign irq                = q.irq;

    // ==================================================
    // Checks
    logic [4:0] low_len;
    always_ff @(posedge aclk) begin
        if (!aresetn || q.sclk) begin
            low_len <= 5'h0;
        end else if (low_len != 5'h1f) begin
            low_len <= low_len + 5'h1;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_ctrl_write;
        wr_go && q.aw_addr == sync_serial_pkg::ADDR_CONTROL && q.w_strb[0];
    endsequence
    sequence s_tx_write_idle;
        wr_go && !q.busy && q.w_strb[0]
        && q.aw_addr == sync_serial_pkg::ADDR_TX0;
    endsequence

    property p_sel_follow;
        s_ctrl_write |=> select_enable_out0 == $past(q.w_data[0])
                         && select_enable_out1 == $past(q.w_data[1]);
    endproperty
    a_sel_follow: assert property (p_sel_follow)
        else $error("enable outputs do not follow control write");

    property p_half_period;
        $rose(serial_clock) && q.bit_cnt != 3'h0
            |-> low_len
                == 5'(5'h1 << q.ctrl[sync_serial_pkg::CTL_DIV_LO +: 2]);
    endproperty
    a_half_period: assert property (p_half_period)
        else $error("shift clock low phase has wrong length");

    property p_busy_state;
        q.state != sync_serial_pkg::ST_IDLE |-> q.busy;
    endproperty
    a_busy_state: assert property (p_busy_state)
        else $error("busy flag low during transfer");

    property p_done_at_bit7;
        $rose(serial_clock) && q.bit_cnt == sync_serial_pkg::LAST_BIT
            |-> q.done;
    endproperty
    a_done_at_bit7: assert property (p_done_at_bit7)
        else $error("done flag not set at last rising edge");

    property p_err_on_busy_read;
        rd_go && araddr == sync_serial_pkg::ADDR_RX && q.busy |=> q.err;
    endproperty
    a_err_on_busy_read: assert property (p_err_on_busy_read)
        else $error("error flag not set on read while busy");

    property p_err_cleared;
        sel_idle && !err_set |=> !q.err;
    endproperty
    a_err_cleared: assert property (p_err_cleared)
        else $error("error flag survives inactive enables");

    property p_rx_released;
        q.busy && q.rx_mode |-> serial_data_oe_n;
    endproperty
    a_rx_released: assert property (p_rx_released)
        else $error("data line driven during receive");

    property p_ctrl_reset;
        $rose(aresetn) |-> q.ctrl == sync_serial_pkg::CONTROL_RESET
                           && !q.done && !q.err && !q.busy;
    endproperty
    a_ctrl_reset: assert property (p_ctrl_reset)
        else $error("control or status not clear after reset");

    property p_tx_start;
        s_tx_write_idle |=> q.busy && !serial_data_oe_n
                            && serial_data_out == $past(q.w_data[7]);
    endproperty
    a_tx_start: assert property (p_tx_start)
        else $error("transmit did not start with msb driven");

    property p_status_read_clears;
        rd_go && araddr == sync_serial_pkg::ADDR_STATUS && !done_set
            |=> !q.done;
    endproperty
    a_status_read_clears: assert property (p_status_read_clears)
        else $error("done flag not cleared by status read");
endmodule : sync_serial_master_port

// ### verif/serial_peripheral_model.sv
// Behavioural serial peripheral on the far side of the port
`timescale 1ns/1ns
module serial_peripheral_model (
    input  wire logic       serial_clock,
    input  wire logic       selected,
    input  wire logic       port_drives,
    input  wire logic       port_bit,
    input  wire logic [7:0] reply_byte,
    output logic            line_level,
    output logic [7:0]      heard_byte
);
    logic [2:0] bit_count = 3'h0;
    // ====================
    // Shared line with pull-up; released line floats high, not to old data
    always_comb begin
        if (port_drives)
            line_level = port_bit;
        else if (selected)
            line_level = reply_byte[3'h7 - bit_count];
        else
            line_level = 1'b1;
    end
    // ====================
    // Next bit after each fall; counter restarts whenever deselected
    always @(negedge serial_clock or negedge selected) begin
        if (!selected)
            bit_count <= 3'h0;
        else
            bit_count <= bit_count + 3'h1;
    end
    // Sample on the rise, msb arrives first
    always @(posedge serial_clock) begin
        if (selected)
            heard_byte <= {heard_byte[6:0], line_level};
    end
endmodule : serial_peripheral_model

// ### verif/testbench.sv
// Self-checking testbench for the synchronous serial master port
`timescale 1ns/1ns
module testbench;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, serial_clock, line_level;
    logic serial_data_out, serial_data_oe_n, sel0, sel1, irq, sclk_q;
    logic rx_phase, drive_seen;
    logic [7:0]  awaddr, araddr, reply_byte, heard_byte;
    logic [31:0] wdata, rdata, seed, v;
    logic [1:0]  bresp, rresp;
    int          n_errors, compares, since, period;
    sync_serial_master_port sync_serial_master_port_inst (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .serial_clock(serial_clock),
        .serial_data_in(line_level), .serial_data_out(serial_data_out),
        .serial_data_oe_n(serial_data_oe_n), .select_enable_out0(sel0),
        .select_enable_out1(sel1), .irq(irq));
    serial_peripheral_model serial_peripheral_model_inst (
        .serial_clock(serial_clock), .selected(sel0 | sel1),
        .port_drives(!serial_data_oe_n), .port_bit(serial_data_out),
        .reply_byte(reply_byte), .line_level(line_level),
        .heard_byte(heard_byte));
    // ====================
    // Clock, shift clock period monitor, line direction monitor
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        sclk_q <= serial_clock;
        since <= (serial_clock && !sclk_q) ? 1 : since + 1;
        if (serial_clock && !sclk_q)
            period <= since;
        if (rx_phase && !serial_data_oe_n)
            drive_seen <= 1'b1;
    end
    // ====================
    // Helpers
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : next_rand
    function automatic int exp_period(input int div);
        return 2 << div;
    endfunction : exp_period
    task automatic complete_run;
        if (n_errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Master holds each channel until its own ready, waits without bound
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        check(bresp, er);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        d = rdata;
        check(rresp, er);
    endtask : rd
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            rd(sync_serial_pkg::ADDR_STATUS, v, sync_serial_pkg::RESP_OKAY);
            n++;
        end while (v[0] !== 1'b0 && n < 300);
    endtask : wait_idle
    // ====================
    // Main sequence
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, rx_phase} = '0;
        {awaddr, araddr, wdata, drive_seen, since, period} = '0;
        aresetn = 1'b0;
        seed = 32'h00014ee3;
        reply_byte = 8'h00;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(sync_serial_pkg::ADDR_CONTROL, v, 2'h0);
        check(v, 32'h0);
        rd(sync_serial_pkg::ADDR_STATUS, v, 2'h0);
        check(v, 32'h0);
        check({sel1, sel0}, 2'h0);
        for (int i = 0; i < 8; i++) begin
            seed = next_rand(seed);
            wr(sync_serial_pkg::ADDR_CONTROL, seed, 2'h0);
            rd(sync_serial_pkg::ADDR_CONTROL, v, 2'h0);
            check(v, {28'h0, seed[3:0]});
            check({sel1, sel0}, seed[1:0]);
        end
        wr(sync_serial_pkg::ADDR_IRQ_EN, 32'h3, 2'h0);
        for (int d = 0; d < 4; d++) begin
            seed = next_rand(seed);
            wr(sync_serial_pkg::ADDR_CONTROL, {28'h0, d[1:0], 2'h2}, 2'h0);
            wr(d[0] ? sync_serial_pkg::ADDR_TX1 : sync_serial_pkg::ADDR_TX0,
               seed, 2'h0);
            rd(sync_serial_pkg::ADDR_STATUS, v, 2'h0);
            check(v[0], 1'b1);
            for (int n = 0; n < 500 && irq !== 1'b1; n++)
                @(posedge aclk);
            rd(sync_serial_pkg::ADDR_STATUS, v, 2'h0);
            check(v[2:1], 2'h1);
            rd(sync_serial_pkg::ADDR_STATUS, v, 2'h0);
            check(v[1], 1'b0);
            wait_idle();
            check(heard_byte, seed[7:0]);
            check(period, exp_period(d));
            wr(sync_serial_pkg::ADDR_IRQ_CLR, 32'h1, 2'h0);
            rd(sync_serial_pkg::ADDR_IRQ_STS, v, 2'h0);
            check({v[0], irq}, 2'h0);
        end
        // Second write lands while busy: refused, error recorded
        seed = next_rand(seed);
        wr(sync_serial_pkg::ADDR_CONTROL, 32'h9, 2'h0);
        wr(sync_serial_pkg::ADDR_TX0, seed, 2'h0);
        wr(sync_serial_pkg::ADDR_TX1, ~seed, 2'h0);
        rd(sync_serial_pkg::ADDR_RX, v, 2'h0);
        rd(sync_serial_pkg::ADDR_STATUS, v, 2'h0);
        check(v[2], 1'b1);
        wait_idle();
        check(heard_byte, seed[7:0]);
        rd(sync_serial_pkg::ADDR_IRQ_STS, v, 2'h0);
        check(v, 32'h3);
        wr(sync_serial_pkg::ADDR_CONTROL, 32'h8, 2'h0);
        rd(sync_serial_pkg::ADDR_STATUS, v, 2'h0);
        check(v, 32'h0);
        // Masked receive: event recorded, interrupt line stays low
        wr(sync_serial_pkg::ADDR_IRQ_CLR, 32'h3, 2'h0);
        wr(sync_serial_pkg::ADDR_IRQ_EN, 32'h0, 2'h0);
        wr(sync_serial_pkg::ADDR_CONTROL, 32'h9, 2'h0);
        seed = next_rand(seed);
        reply_byte = seed[7:0];
        rx_phase = 1'b1;
        rd(sync_serial_pkg::ADDR_RX, v, 2'h0);
        wait_idle();
        rd(sync_serial_pkg::ADDR_RX, v, 2'h0);
        check(v, {24'h0, seed[7:0]});
        wait_idle();
        rx_phase = 1'b0;
        check(drive_seen, 1'b0);
        rd(sync_serial_pkg::ADDR_IRQ_STS, v, 2'h0);
        check({v[0], irq}, 2'h2);
        // Unmapped, write-only and read-only places
        wr(sync_serial_pkg::ADDR_CONTROL, 32'h0, 2'h0);
        rd(8'h04, v, sync_serial_pkg::RESP_SLVERR);
        wr(8'h04, 32'h0, sync_serial_pkg::RESP_SLVERR);
        rd(sync_serial_pkg::ADDR_TX0, v, 2'h0);
        check(v, 32'h0);
        wr(sync_serial_pkg::ADDR_STATUS, 32'hffff, 2'h0);
        rd(sync_serial_pkg::ADDR_STATUS, v, 2'h0);
        check(v, 32'h0);
        complete_run();
    end
    // Whole run needs several hundred cycles; a hang is cut well beyond
    initial begin
        repeat (30000) @(posedge aclk);
        n_errors++;
        complete_run();
    end
endmodule : testbench
